// File: src/wss_pkg.sv
// constants, register map and types shared by the watchdog service sequencer
package wss_pkg;
  // bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h3C;
  localparam logic [7:0] SERVICE_IDX = 8'h3F;
  localparam logic [7:0] STATUS_IDX = 8'h40;
  localparam logic [7:0] MASK_IDX = 8'h41;
  localparam logic [7:0] ELAPSED_IDX = 8'h42;
  // service keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // control register fields
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_WINDOW_BIT = 7;
  localparam logic [2:0] RATE_RESET = 3'h0;
  localparam logic [2:0] RATE_OFF = 3'h0;
  localparam logic WINDOW_RESET = 1'b0;
  // status / mask fields
  localparam int STATUS_W = 4;
  localparam int ST_WRONG = 0;
  localparam int ST_EARLY = 1;
  localparam int ST_EXPIRE = 2;
  localparam int ST_RESTART = 3;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 4'h0;
  localparam logic [STATUS_W-1:0] MASK_RESET = 4'h0;
  // time-out counter
  localparam int COUNT_W = 25;
  localparam logic [4:0] EXP_MIN = 5'h02;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // key sequence progress
  typedef enum logic [0:0] {
    SVC_IDLE = 1'b0,
    SVC_ARMED = 1'b1
  } wss_svc_t;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] regAddr(input logic [7:0] idx);
    regAddr = {idx, 2'b00};
  endfunction

  // period exponent for each rate select value, zero when disabled
  function automatic logic [4:0] rateExp(input logic [2:0] sel);
    case (sel)
      3'h1: rateExp = 5'h0E;
      3'h2: rateExp = 5'h10;
      3'h3: rateExp = 5'h12;
      3'h4: rateExp = 5'h14;
      3'h5: rateExp = 5'h16;
      3'h6: rateExp = 5'h17;
      3'h7: rateExp = 5'h18;
      default: rateExp = 5'h00;
    endcase
  endfunction
endpackage

// File: src/wss_timeout_counter.sv
// watchdog time-out counter with window detection
`timescale 1ns/1ps
module wss_timeout_counter #(
  parameter int EXP_REDUCE = 0 // shortens every period for simulation
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] rateSel,
  input wire logic restart,
  output logic [wss_pkg::COUNT_W-1:0] elapsed,
  output logic expired,
  output logic windowOpen
);
  import wss_pkg::*;

  logic [4:0] periodExp; // effective exponent after reduction
  logic [COUNT_W-1:0] periodLast; // last count of a period
  logic [COUNT_W-1:0] windowStart; // first count of the final quarter
  logic [COUNT_W-1:0] next_elapsed;
  logic next_expired;

  // period shape; clamp keeps the quarter nonzero when heavily reduced
  always_comb begin
    periodExp = rateExp(rateSel) - 5'(EXP_REDUCE);
    if (periodExp < EXP_MIN || periodExp > rateExp(rateSel)) begin
      periodExp = EXP_MIN;
    end
    periodLast = (COUNT_W'(1) << periodExp) - COUNT_W'(1);
    windowStart = (COUNT_W'(1) << periodExp) - (COUNT_W'(1) << (periodExp - 5'h02));
    windowOpen = (elapsed >= windowStart);
  end

  // count, wrap on expiry, hold at zero while disabled
  always_comb begin
    next_elapsed = elapsed + COUNT_W'(1);
    next_expired = 1'b0;
    if (rateSel == RATE_OFF || restart) begin
      next_elapsed = '0;
    end else if (elapsed == periodLast) begin
      next_elapsed = '0;
      next_expired = 1'b1;
    end
  end

  // register the count
  always_ff @(posedge clk) begin
    if (rst) begin
      elapsed <= '0;
      expired <= 1'b0;
    end else begin
      elapsed <= next_elapsed;
      expired <= next_expired;
    end
  end
endmodule

// File: src/wss_watchdog_service_sequencer.sv
// watchdog service sequencer with AXI4-Lite registers and interrupt
// Notes on behaviour
// - rate zero: service writes ignored entirely
// - enabled: non-key byte causes watchdog reset
// - first key then second key restarts count
// - other accesses may separate the keys
// - window mode: early write causes reset
// - repeated first keys are harmless
// - window mode, after restart: writes premature until window
// - nonzero rate load starts a period
// - expiry requests full system reset
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module wss_watchdog_service_sequencer #(
  parameter int EXP_REDUCE = 0 // subtracted from period exponent, 0 in silicon
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [wss_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [wss_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wss_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [wss_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic wdogResetReq
);
  import wss_pkg::*;

  // bus holding state
  logic awHeld, next_awHeld;
  logic [ADDR_W-1:0] awAddr, next_awAddr;
  logic wHeld, next_wHeld;
  logic [7:0] wByte, next_wByte; // only lane 0 matters to any register
  logic wLane0, next_wLane0;
  logic next_awready, next_wready, next_arready;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [DATA_W-1:0] next_rdata;
  // block state
  logic [2:0] rateSel, next_rateSel; // timeout_rate_select
  logic windowMode, next_windowMode; // window_mode_enable
  logic [STATUS_W-1:0] status, next_status;
  logic [STATUS_W-1:0] mask, next_mask;
  wss_svc_t svcState, next_svcState;
  logic next_irq, next_resetReq;
  // events and helpers
  logic doWrite, svcWrite, enabled, earlyWin;
  logic wrongEv, earlyEv, restartEv, startEv, counterRestart;
  logic [COUNT_W-1:0] elapsed;
  logic expired, windowOpen;

  // watchdog_timer counter
  wss_timeout_counter #(.EXP_REDUCE(EXP_REDUCE)) u_counter (
    .clk(clk),
    .rst(rst),
    .rateSel(rateSel),
    .restart(counterRestart),
    .elapsed(elapsed),
    .expired(expired),
    .windowOpen(windowOpen)
  );

  // a write runs once both halves are held and the response slot is free
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign svcWrite = doWrite && awAddr == regAddr(SERVICE_IDX) && wLane0;
  assign enabled = (rateSel != RATE_OFF);
  // in window mode software must keep keys inside the final quarter; early ones trip
  assign earlyWin = windowMode && !windowOpen;

  // bus channels, register file, key sequencer
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wByte = wByte;
    next_wLane0 = wLane0;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_rateSel = rateSel;
    next_windowMode = windowMode;
    next_mask = mask;
    next_svcState = svcState;
    wrongEv = 1'b0;
    earlyEv = 1'b0;
    restartEv = 1'b0;
    startEv = 1'b0;
    next_status = status;
    // address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wByte = s_axi_wdata[7:0];
      next_wLane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // write decode
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (awAddr)
        regAddr(CTRL_IDX): begin
          if (wLane0) begin
            next_rateSel = wByte[CTRL_RATE_LSB +: 3];
            next_windowMode = wByte[CTRL_WINDOW_BIT];
            startEv = (wByte[CTRL_RATE_LSB +: 3] != RATE_OFF);
          end
        end
        regAddr(MASK_IDX): begin
          if (wLane0) begin
            next_mask = wByte[STATUS_W-1:0];
          end
        end
        regAddr(SERVICE_IDX), regAddr(STATUS_IDX), regAddr(ELAPSED_IDX): begin
          next_bresp = RESP_OKAY; // read-only ones just ignore the data
        end
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    // key sequencer; disabled watchdog ignores the write entirely
    if (svcWrite && enabled) begin
      if (earlyWin) begin
        earlyEv = 1'b1; // any value, including keys, before the window
      end else if (wByte == KEY_FIRST) begin
        next_svcState = SVC_ARMED; // repeats keep it armed
      end else if (wByte == KEY_SECOND) begin
        if (svcState == SVC_ARMED) begin
          restartEv = 1'b1; // armed state survives other accesses
          next_svcState = SVC_IDLE;
        end
      end else begin
        wrongEv = 1'b1;
      end
    end
    // any reset cause drops a half-done sequence
    if (wrongEv || earlyEv || expired) begin
      next_svcState = SVC_IDLE;
    end
    // read channel; a status read clears it but new events still land
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      case (s_axi_araddr)
        regAddr(CTRL_IDX): begin
          next_rdata[CTRL_RATE_LSB +: 3] = rateSel;
          next_rdata[CTRL_WINDOW_BIT] = windowMode;
        end
        regAddr(SERVICE_IDX): next_rdata = '0; // always reads zero
        regAddr(STATUS_IDX): begin
          next_rdata[STATUS_W-1:0] = status;
          next_status = '0;
        end
        regAddr(MASK_IDX): next_rdata[STATUS_W-1:0] = mask;
        regAddr(ELAPSED_IDX): next_rdata[COUNT_W-1:0] = elapsed;
        default: next_rresp = RESP_SLVERR;
      endcase
    end
    // set wins over the read clear
    next_status[ST_WRONG] = next_status[ST_WRONG] | wrongEv;
    next_status[ST_EARLY] = next_status[ST_EARLY] | earlyEv;
    next_status[ST_EXPIRE] = next_status[ST_EXPIRE] | expired;
    next_status[ST_RESTART] = next_status[ST_RESTART] | restartEv;
    next_resetReq = wrongEv || earlyEv || expired;
    next_irq = |(next_status & next_mask);
    // one request slot per channel keeps the slave single-outstanding
    next_awready = !next_awHeld;
    next_wready = !next_wHeld;
    next_arready = !next_rvalid;
  end

  // counter restarts on a good sequence, a rate load or after any reset cause
  assign counterRestart = restartEv || startEv || wrongEv || earlyEv;

  // register everything
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      awAddr <= '0;
      wHeld <= 1'b0;
      wByte <= 8'h00;
      wLane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      rateSel <= RATE_RESET;
      windowMode <= WINDOW_RESET;
      status <= STATUS_RESET;
      mask <= MASK_RESET;
      svcState <= SVC_IDLE;
      irq <= 1'b0;
      wdogResetReq <= 1'b0;
    end else begin
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wByte <= next_wByte;
      wLane0 <= next_wLane0;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      rateSel <= next_rateSel;
      windowMode <= next_windowMode;
      status <= next_status;
      mask <= next_mask;
      svcState <= next_svcState;
      irq <= next_irq;
      wdogResetReq <= next_resetReq;
    end
  end

  // checks on the sequencer
  a_disabled_ignore: assert property (@(posedge clk) disable iff (rst)
    svcWrite && !enabled |=> !wdogResetReq && svcState == $past(svcState))
    else $error("service write acted while disabled");
  a_bad_key_reset: assert property (@(posedge clk) disable iff (rst)
    svcWrite && enabled && !earlyWin && wByte != KEY_FIRST && wByte != KEY_SECOND
    |=> wdogResetReq)
    else $error("wrong key gave no reset");
  a_key_restart: assert property (@(posedge clk) disable iff (rst)
    svcWrite && enabled && !earlyWin && wByte == KEY_SECOND && svcState == SVC_ARMED
    |=> elapsed == '0 && svcState == SVC_IDLE && wdogResetReq == $past(expired))
    else $error("key pair did not restart");
  a_armed_holds: assert property (@(posedge clk) disable iff (rst)
    svcState == SVC_ARMED && !svcWrite && !expired |=> svcState == SVC_ARMED)
    else $error("armed state lost between accesses");
  a_expiry_reset: assert property (@(posedge clk) disable iff (rst)
    expired |=> wdogResetReq && svcState == SVC_IDLE)
    else $error("expiry gave no reset");
  a_early_write: assert property (@(posedge clk) disable iff (rst)
    svcWrite && enabled && earlyWin |=> wdogResetReq ##1 elapsed == COUNT_W'(1))
    else $error("premature write gave no reset");
  a_repeat_first: assert property (@(posedge clk) disable iff (rst)
    svcWrite && enabled && !earlyWin && wByte == KEY_FIRST && !expired
    |=> svcState == SVC_ARMED && !wdogResetReq)
    else $error("first key was penalised");
  a_window_closed: assert property (@(posedge clk) disable iff (rst)
    restartEv && windowMode && !startEv |=> !windowOpen)
    else $error("window open after restart");
  a_rate_start: assert property (@(posedge clk) disable iff (rst)
    startEv |=> elapsed == '0 ##1 elapsed == COUNT_W'(1))
    else $error("rate load did not start period");
  a_reset_pulse: assert property (@(posedge clk) disable iff (rst)
    $rose(wdogResetReq) |=> !wdogResetReq)
    else $error("reset request longer than one cycle");
endmodule

// File: tb/wss_watchdog_service_sequencer_test.sv
// self-checking bench for the watchdog service sequencer
`timescale 1ns/1ps
module wss_watchdog_service_sequencer_test;
  import wss_pkg::*;
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, wdogResetReq;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int fails = 0; // mismatches seen
  int n_tests = 0; // comparisons made
  int pulses = 0; // cycles with reset request high
  logic [1:0] lastBresp; // response code of the last write
  // rate 1 becomes 16 cycles, rate 2 64, rate 7 16384
  wss_watchdog_service_sequencer #(.EXP_REDUCE(10)) dut (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .wdogResetReq(wdogResetReq)
  );
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // a stuck request shows up as extra counted cycles
  always @(posedge clk) begin
    if (!rst && wdogResetReq === 1'b1) pulses++;
  end
  // verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one comparison
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (exp !== got) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // let registered outputs settle after the last edge
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // write: offer address and data together, release each when taken
  task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int t;
    logic gotA, gotW;
    gotA = 0;
    gotW = 0;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(gotA && gotW) && t < 50) begin
      @(posedge clk);
      t++;
      if (awvalid && awready) begin
        gotA = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        gotW = 1;
        wvalid <= 1'b0;
      end
    end
    // bready stays high until bvalid is sampled
    do begin
      @(posedge clk);
      t++;
    end while (bvalid !== 1'b1 && t < 100);
    lastBresp = bresp;
    bready <= 1'b0;
    if (t >= 100) check("write timeout", 0, 1);
  endtask
  // read: hold arvalid until taken, rready until rvalid
  task automatic axiRead(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    int t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (arready !== 1'b1 && t < 50);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && t < 100) begin
      @(posedge clk);
      t++;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (t >= 100) check("read timeout", 0, 1);
  endtask
  // read status and compare, which also clears it
  task automatic expectStatus(input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    axiRead(regAddr(STATUS_IDX), v, r);
    check("status", exp, v);
  endtask
  // disabled: service writes do nothing; unmapped and service reads
  task automatic testDisabled();
    int p0;
    logic [31:0] v;
    logic [1:0] r;
    p0 = pulses;
    axiWrite(regAddr(SERVICE_IDX), 32'h12);
    axiWrite(regAddr(SERVICE_IDX), 32'h55);
    axiWrite(regAddr(SERVICE_IDX), 32'hAA);
    check("service wresp", RESP_OKAY, lastBresp);
    settle();
    check("pulses off", 0, pulses - p0);
    axiWrite(regAddr(8'h10), 32'h0);
    check("unmapped wresp", RESP_SLVERR, lastBresp);
    expectStatus(32'h0);
    axiRead(regAddr(8'h10), v, r);
    check("unmapped resp", RESP_SLVERR, r);
    axiRead(regAddr(SERVICE_IDX), v, r);
    check("service read", 32'h0, v);
    $display("test disabled done");
  endtask
  // wrong byte while enabled, masked so irq stays low
  task automatic testWrongKey();
    int p0;
    axiWrite(regAddr(CTRL_IDX), 32'h7);
    expectStatus(32'h0);
    p0 = pulses;
    axiWrite(regAddr(SERVICE_IDX), 32'h12);
    settle();
    check("pulses wrong", 1, pulses - p0);
    check("irq masked", 0, irq);
    expectStatus(32'h1);
    expectStatus(32'h0);
    $display("test wrong key done");
  endtask
  // keys split by other accesses, first key repeated
  task automatic testRestart();
    int p0;
    logic [31:0] v;
    logic [1:0] r;
    repeat (100) @(posedge clk);
    p0 = pulses;
    axiWrite(regAddr(SERVICE_IDX), 32'h55);
    axiRead(regAddr(ELAPSED_IDX), v, r);
    check("elapsed high", 1, v >= 20);
    axiWrite(regAddr(SERVICE_IDX), 32'h55);
    axiWrite(regAddr(SERVICE_IDX), 32'hAA);
    axiRead(regAddr(ELAPSED_IDX), v, r);
    check("elapsed low", 1, v < 20);
    check("pulses ok", 0, pulses - p0);
    expectStatus(32'h8);
    $display("test restart done");
  endtask
  // window mode: early write, service in window, early again
  task automatic testWindow();
    int p0;
    int n;
    logic [31:0] v;
    logic [1:0] r;
    axiWrite(regAddr(MASK_IDX), 32'h2);
    axiWrite(regAddr(CTRL_IDX), 32'h82);
    axiRead(regAddr(CTRL_IDX), v, r);
    check("ctrl readback", 32'h82, v);
    axiRead(regAddr(MASK_IDX), v, r);
    check("mask readback", 32'h2, v);
    expectStatus(32'h0);
    p0 = pulses;
    axiWrite(regAddr(SERVICE_IDX), 32'h55);
    settle();
    check("pulses early", 1, pulses - p0);
    check("irq set", 1, irq);
    expectStatus(32'h2);
    settle();
    check("irq clear", 0, irq);
    // count restarted by the early write; wait for the last quarter
    n = 0;
    do begin
      axiRead(regAddr(ELAPSED_IDX), v, r);
      n++;
    end while (v < 48 && n < 40);
    p0 = pulses;
    axiWrite(regAddr(SERVICE_IDX), 32'h55);
    axiWrite(regAddr(SERVICE_IDX), 32'hAA);
    settle();
    check("pulses window", 0, pulses - p0);
    expectStatus(32'h8);
    axiWrite(regAddr(SERVICE_IDX), 32'h55);
    settle();
    check("pulses rearm", 1, pulses - p0);
    expectStatus(32'h2);
    $display("test window done");
  endtask
  // no service at all: expiry after 16 cycles
  task automatic testExpiry();
    int p0;
    axiWrite(regAddr(CTRL_IDX), 32'h1);
    expectStatus(32'h0);
    p0 = pulses;
    repeat (20) @(posedge clk);
    #1;
    check("pulses expiry", 1, pulses - p0);
    expectStatus(32'h4);
    $display("test expiry done");
  endtask
  // watchdog against a hang
  initial begin
    #(8 * 20000);
    fails++;
    $display("Error watchdog expected finish seen hang");
    tally_and_finish();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    testDisabled();
    testWrongKey();
    testRestart();
    testWindow();
    testExpiry();
    tally_and_finish();
  end
endmodule
